// *** core/swh_host.sv ***
module swh_host
  import swh_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic CORE_CLK, // core clock, 125 MHz
  input wire logic SYS_RST, // synchronous reset, high
  input wire logic CMD_VALID, // command offered
  input wire logic [1:0] CMD_OP, // reset, write byte, read byte
  input wire logic [7:0] CMD_DATA, // byte to write
  input wire logic CMD_OVERDRIVE, // speed, taken with reset
  output logic CMD_READY, // command taken when high
  output logic CMD_REFUSED, // read dropped when not armed, or unused op code
  output logic PRESENT, // presence seen since last reset
  output logic OVERDRIVE, // speed in use
  output logic RD_VALID, // read byte waiting
  output logic [7:0] RD_DATA, // read byte
  input wire logic RD_READY, // read byte taken
  output logic SHIFT_CLK, // serial shift clock, idles low
  input wire logic LINE_IN, // single_wire_data_pin level
  output logic LINE_OUT, // single_wire_data_pin drive value
  output logic LINE_OE // single_wire_data_pin pulled low
);
  typedef struct packed {
    swh_state_t st;
    swh_op_t op;
    logic od;
    logic present;
    logic armed;
    logic sync1;
    logic sync2;
    logic sclk;
    logic oe;
    logic [HALF_W-1:0] half;
    logic [HALF_W-1:0] half_lim;
    logic [2:0] bit_idx;
    logic [7:0] frame;
    logic [7:0] cap;
    logic [2:0] slot;
    logic [7:0] byte_sh;
    logic [7:0] rx;
    logic cmd_ready;
    logic refused;
    logic push_v;
    logic [7:0] push_d;
    logic fstart;
  } swh_host_t;

  swh_host_t s_r;
  swh_host_t s_nxt;
  logic bit_val;

  swh_strm_if #(.W(8)) push_if ();
  swh_strm_if #(.W(8)) pop_if ();

  swh_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .push(push_if.snk),
    .pop(pop_if.src)
  );

  assign push_if.valid = s_r.push_v;
  assign push_if.data = s_r.push_d;
  assign pop_if.ready = RD_READY;
  assign RD_VALID = pop_if.valid;
  assign RD_DATA = pop_if.data;

  assign CMD_READY = s_r.cmd_ready;
  assign CMD_REFUSED = s_r.refused;
  assign PRESENT = s_r.present;
  assign OVERDRIVE = s_r.od;
  assign SHIFT_CLK = s_r.sclk;
  assign LINE_OE = s_r.oe;
  assign LINE_OUT = 1'b0;

  // launch a frame: first rising edge puts out the top bit
  function automatic swh_host_t launch(swh_host_t x, logic [7:0] f,
                                       logic [HALF_W-1:0] lim);
    x.frame = f;
    x.half_lim = lim;
    x.half = '0;
    x.bit_idx = '0;
    x.sclk = 1'b1;
    x.oe = ~f[FRAME_BITS-1];
    x.cap = '0;
    x.fstart = 1'b1;
    x.st = S_FRAME;
    return x;
  endfunction

  function automatic logic [HALF_W-1:0] data_half(logic od);
    return od ? OD_BIT_HALF : STD_BIT_HALF;
  endfunction

  function automatic logic [HALF_W-1:0] rst_half(logic od);
    return od ? OD_RST_HALF : STD_RST_HALF;
  endfunction

  function automatic logic [7:0] wr_frame(logic b);
    return b ? ONE_FRAME : ZERO_FRAME;
  endfunction

  assign bit_val = s_r.cap == READ_FRAME;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync1 = LINE_IN;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.refused = 1'b0;
    s_nxt.fstart = 1'b0;
    case (s_r.st)
      S_IDLE:
      begin
        s_nxt.cmd_ready = 1'b1;
        if (CMD_VALID && s_r.cmd_ready)
        begin
          s_nxt.cmd_ready = 1'b0;
          s_nxt.op = swh_op_t'(CMD_OP);
          s_nxt.byte_sh = CMD_DATA;
          s_nxt.slot = '0;
          case (CMD_OP)
            SWH_OP_RESET:
            begin
              s_nxt.od = CMD_OVERDRIVE;
              s_nxt.present = 1'b0;
              s_nxt.armed = 1'b0;
              s_nxt = launch(s_nxt, RST_FRAME, rst_half(CMD_OVERDRIVE));
            end
            SWH_OP_WRITE:
            begin
              s_nxt = launch(s_nxt, wr_frame(CMD_DATA[0]), data_half(s_r.od));
            end
            SWH_OP_READ:
            begin
              if (s_r.armed)
                s_nxt = launch(s_nxt, READ_FRAME, data_half(s_r.od));
              else
              begin
                s_nxt.refused = 1'b1;
                s_nxt.cmd_ready = 1'b1;
              end
            end
            default:
            begin
              s_nxt.refused = 1'b1;
              s_nxt.cmd_ready = 1'b1;
            end
          endcase
        end
      end
      S_FRAME:
      begin
        s_nxt.half = s_r.half + HALF_ONE;
        if (s_r.half == s_r.half_lim - HALF_ONE)
        begin
          s_nxt.half = '0;
          if (s_r.sclk)
          begin
            s_nxt.sclk = 1'b0;
            s_nxt.cap = {s_r.cap[6:0], s_r.sync2};
          end
          else if (s_r.bit_idx == LAST_BIT)
          begin
            s_nxt.oe = 1'b0;
            s_nxt.st = S_SLOT_END;
          end
          else
          begin
            s_nxt.bit_idx = s_r.bit_idx + BIT_ONE;
            s_nxt.frame = {s_r.frame[6:0], 1'b0};
            s_nxt.sclk = 1'b1;
            s_nxt.oe = ~s_r.frame[FRAME_BITS-2];
          end
        end
      end
      S_SLOT_END:
      begin
        if (s_r.op == SWH_OP_RESET)
        begin
          if (s_r.cap == PRESENCE_FRAME)
          begin
            s_nxt.present = 1'b1;
            s_nxt.cmd_ready = 1'b1;
            s_nxt.st = S_IDLE;
          end
          else
            s_nxt = launch(s_nxt, RST_FRAME, rst_half(s_r.od));
        end
        else
        begin
          s_nxt.rx = {bit_val, s_r.rx[7:1]};
          if (s_r.slot != LAST_BIT)
          begin
            s_nxt.slot = s_r.slot + BIT_ONE;
            s_nxt.byte_sh = {1'b0, s_r.byte_sh[7:1]};
            if (s_r.op == SWH_OP_WRITE)
              s_nxt = launch(s_nxt, wr_frame(s_r.byte_sh[1]), s_r.half_lim);
            else
              s_nxt = launch(s_nxt, READ_FRAME, s_r.half_lim);
          end
          else if (s_r.op == SWH_OP_WRITE)
          begin
            s_nxt.armed = 1'b1;
            s_nxt.cmd_ready = 1'b1;
            s_nxt.st = S_IDLE;
          end
          else
          begin
            s_nxt.push_v = 1'b1;
            s_nxt.push_d = {bit_val, s_r.rx[7:1]};
            s_nxt.st = S_PUSH;
          end
        end
      end
      S_PUSH:
      begin
        // full fifo stalls the next command here
        if (push_if.ready)
        begin
          s_nxt.push_v = 1'b0;
          s_nxt.cmd_ready = 1'b1;
          s_nxt.st = S_IDLE;
        end
      end
      default:
        s_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence rst_start;
    s_r.fstart && s_r.op == SWH_OP_RESET;
  endsequence

  sequence wr_start;
    s_r.fstart && s_r.op == SWH_OP_WRITE;
  endsequence

  sequence rd_start;
    s_r.fstart && s_r.op == SWH_OP_READ;
  endsequence

  sequence slot_done(swh_op_t o);
    s_r.st == S_SLOT_END && s_r.op == o;
  endsequence

  frame_shape_a: assert property (
    s_r.st == S_SLOT_END |-> $past(s_r.bit_idx) == LAST_BIT && !s_r.sclk)
    else $error("frame not eight bits or clock not low");

  std_rates_a: assert property (
    s_r.fstart && !s_r.od |-> s_r.half_lim ==
      (s_r.op == SWH_OP_RESET ? STD_RST_HALF : STD_BIT_HALF))
    else $error("standard speed rate wrong");

  od_reset_rate_a: assert property (
    rst_start and s_r.od |-> s_r.half_lim == OD_RST_HALF)
    else $error("overdrive reset rate wrong");

  od_data_rate_a: assert property (
    s_r.fstart && s_r.od && s_r.op != SWH_OP_RESET
      |-> s_r.half_lim == OD_BIT_HALF)
    else $error("overdrive data rate wrong");

  reset_frame_a: assert property (
    rst_start |-> s_r.frame == RST_FRAME && s_r.oe)
    else $error("reset frame wrong");

  presence_retry_a: assert property (
    slot_done(SWH_OP_RESET) ##0 s_r.cap != PRESENCE_FRAME
      |=> rst_start ##0 !s_r.present)
    else $error("reset not repeated");

  // a held command may be taken in the first cycle that idle is reached
  presence_done_a: assert property (
    slot_done(SWH_OP_RESET) ##0 s_r.cap == PRESENCE_FRAME
      |=> s_r.present && s_r.cmd_ready && s_r.st == S_IDLE)
    else $error("presence not reported");

  write_slot_a: assert property (
    wr_start |-> s_r.frame == wr_frame(s_r.byte_sh[0]))
    else $error("write slot pattern wrong");

  lsb_order_a: assert property (
    slot_done(SWH_OP_WRITE) ##0 s_r.slot != LAST_BIT
      |=> wr_start ##0 s_r.slot == $past(s_r.slot) + BIT_ONE)
    else $error("write slot order wrong");

  read_slot_a: assert property (
    rd_start |-> s_r.frame == READ_FRAME && s_r.armed)
    else $error("read slot wrong");

  read_decode_a: assert property (
    slot_done(SWH_OP_READ) |=> s_r.rx[7] == $past(bit_val))
    else $error("read bit decode wrong");

  idle_release_a: assert property (
    s_r.st != S_FRAME |-> !LINE_OE && !SHIFT_CLK)
    else $error("line held outside frame");
endmodule

// *** core/swh_pkg.sv ***
package swh_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int STD_RST_HZ = 16000;
  localparam int STD_BIT_HZ = 125000;
  localparam int OD_RST_HZ = 100500;
  localparam int OD_BIT_HZ = 500000;
  localparam int HALF_W = 12;
  // half periods of the shift clock, rounded down
  localparam logic [HALF_W-1:0] STD_RST_HALF =
    HALF_W'(CLK_HZ / (2 * STD_RST_HZ));
  localparam logic [HALF_W-1:0] STD_BIT_HALF =
    HALF_W'(CLK_HZ / (2 * STD_BIT_HZ));
  localparam logic [HALF_W-1:0] OD_RST_HALF =
    HALF_W'(CLK_HZ / (2 * OD_RST_HZ));
  localparam logic [HALF_W-1:0] OD_BIT_HALF =
    HALF_W'(CLK_HZ / (2 * OD_BIT_HZ));
  localparam logic [HALF_W-1:0] HALF_ONE = 12'h001;
  localparam int FRAME_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BIT_ONE = 3'h1;
  localparam logic [7:0] RST_FRAME = 8'h07;
  localparam logic [7:0] PRESENCE_FRAME = 8'h05;
  localparam logic [7:0] ZERO_FRAME = 8'h01;
  localparam logic [7:0] ONE_FRAME = 8'h7F;
  localparam logic [7:0] READ_FRAME = 8'h7F;
  localparam logic [7:0] skip_address_cmd = 8'hCC;
  localparam logic [7:0] start_conversion_cmd = 8'h44;
  localparam logic [7:0] read_scratch_cmd = 8'hBE;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {SWH_OP_RESET, SWH_OP_WRITE, SWH_OP_READ} swh_op_t;
  typedef enum logic [1:0] {S_IDLE, S_FRAME, S_SLOT_END, S_PUSH} swh_state_t;
endpackage

// *** core/swh_strm_if.sv ***
interface swh_strm_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** core/swh_fifo.sv ***
// depth must be a power of two: pointers wrap freely
module swh_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, high
  swh_strm_if.snk push, // filling side
  swh_strm_if.src pop // draining side
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } swh_fifo_t;
  swh_fifo_t s_r;
  swh_fifo_t s_nxt;
  logic wr;
  logic rd;

  assign push.ready = ~s_r.full;
  assign pop.valid = ~s_r.empty;
  assign pop.data = s_r.mem[s_r.rp];
  assign wr = push.valid & ~s_r.full;
  assign rd = pop.ready & ~s_r.empty;

  always_comb
  begin
    s_nxt = s_r;
    if (wr)
    begin
      s_nxt.mem[s_r.wp] = push.data;
      s_nxt.wp = s_r.wp + AW'(1);
    end
    if (rd)
      s_nxt.rp = s_r.rp + AW'(1);
    if (wr && !rd)
      s_nxt.cnt = s_r.cnt + (AW+1)'(1);
    else if (rd && !wr)
      s_nxt.cnt = s_r.cnt - (AW+1)'(1);
    // flags registered so the ports come from flops
    s_nxt.full = s_nxt.cnt == (AW+1)'(DEPTH);
    s_nxt.empty = s_nxt.cnt == '0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.empty <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    s_r.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count past depth");
endmodule

// *** tb/swh_sensor_model.sv ***
module swh_sensor_model
  import swh_pkg::*;
(
  input wire logic line, // wire level, pulled up
  input wire logic od, // overdrive timing in use
  input wire logic mute, // hold back the presence answer
  input wire logic [15:0] reply, // bits returned, lsb first
  output logic pull // pulls the wire low
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime t0;
  int lo;
  int rb;
  int nb;
  logic [7:0] sh;
  logic rd;
  logic ans;
  initial
  begin
    pull = 1'b0;
    rd = 1'b0;
    nb = 0;
    rb = 0;
    sh = 8'h00;
    forever
    begin
      @(negedge line);
      t0 = $realtime;
      @(posedge line);
      lo = int'($realtime - t0);
      if (lo > (od ? 24000 : 160000))
      begin
        rd = 1'b0;
        nb = 0;
        rb = 0;
        // answer fixed at release, so a later unmute waits a frame
        ans = !mute;
        // slot width taken from the host's own low time
        #(lo * 3 / 20);
        pull = ans;
        #(lo / 4);
        pull = 1'b0;
      end
      else if (rd)
      begin
        pull = !reply[rb];
        rb = (rb + 1) % 16;
        #(lo * 3);
        pull = 1'b0;
      end
      else
      begin
        sh = {lo < (od ? 4000 : 16000), sh[7:1]};
        nb = (nb + 1) % 8;
        rd = nb == 0 && sh == read_scratch_cmd;
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
module tb_top
  import swh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ODH = int'(OD_BIT_HALF);
  logic clk, rst, cv, co, rdr, sens_od, mute, line, pull, ref_seen;
  logic c_rdy, c_ref, pres, odv, rv, sclk, oe;
  logic [1:0] op;
  logic [7:0] cd, rdat;
  logic [15:0] reply;
  int errors, checked, lo_cnt, pulses, seed;
  int exp_q[$];

  swh_host #(.DEPTH(16)) uut (.CORE_CLK(clk), .SYS_RST(rst),
    .CMD_VALID(cv), .CMD_OP(op), .CMD_DATA(cd), .CMD_OVERDRIVE(co),
    .CMD_READY(c_rdy), .CMD_REFUSED(c_ref), .PRESENT(pres),
    .OVERDRIVE(odv), .RD_VALID(rv), .RD_DATA(rdat), .RD_READY(rdr),
    .SHIFT_CLK(sclk), .LINE_IN(line), .LINE_OUT(), .LINE_OE(oe));
  swh_sensor_model sensor (.line(line), .od(sens_od), .mute(mute),
    .reply(reply), .pull(pull));
  assign line = !((oe === 1'b1) || pull);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_len(input int g, input int e);
    checked++;
    if (g != e)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic exp_byte(input logic [7:0] b, input int h);
    for (int i = 0; i < 8; i++)
      exp_q.push_back(b[i] ? 2 * h : 14 * h);
  endtask

  task automatic issue(input logic [1:0] o, input logic [7:0] d);
    logic took;
    took = 1'b0;
    op = o;
    cd = d;
    co = sens_od;
    cv = 1'b1;
    for (int n = 0; n < 1000 && !took; n++)
    begin
      @(posedge clk);
      took = c_rdy === 1'b1;
    end
    #1 cv = 1'b0;
    cd = 8'($random(seed));
    // a command never taken is a hang
    if (!took)
    begin
      errors++;
      summarize();
    end
  endtask

  task automatic done;
    for (int n = 0; n < 70000 && c_rdy !== 1'b1; n++)
      @(posedge clk);
    #1;
    // a job that never finishes is a hang
    if (c_rdy !== 1'b1)
    begin
      errors++;
      summarize();
    end
  endtask

  task automatic pop_chk(input logic [7:0] e);
    chk_bit(rv, 1'b1);
    chk_byte(rdat, e);
    rdr = 1'b1;
    @(posedge clk);
    #1 rdr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // low time of every host slot, in clocks
  always @(posedge clk)
  begin
    if (c_ref === 1'b1)
      ref_seen = 1'b1;
    if (oe === 1'b1)
      lo_cnt++;
    else if (lo_cnt > 0)
    begin
      pulses++;
      chk_len(lo_cnt, exp_q.size() > 0 ? exp_q.pop_front() : 0);
      lo_cnt = 0;
    end
  end

  initial
  begin
    #(200000 * 8);
    errors++;
    summarize();
  end

  initial
  begin
    seed = 45365;
    errors = 0;
    checked = 0;
    lo_cnt = 0;
    pulses = 0;
    {cv, co, rdr, sens_od, mute, ref_seen} = 6'h00;
    op = 2'h0;
    cd = 8'h00;
    rst = 1'b1;
    reply = 16'($random(seed));
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    // standard speed reset frame
    exp_q.push_back(10 * int'(STD_RST_HALF));
    issue(2'h0, 8'h00);
    done();
    chk_bit(pres, 1'b1);
    chk_bit(odv, 1'b0);
    // read before any write, then the unused code
    for (int i = 2; i < 4; i++)
    begin
      ref_seen = 1'b0;
      issue(2'(i), 8'h00);
      done();
      repeat (3) @(posedge clk);
      chk_bit(ref_seen, 1'b1);
    end
    chk_len(pulses, 1);
    // overdrive reset, first answer withheld
    sens_od = 1'b1;
    mute = 1'b1;
    repeat (2) exp_q.push_back(10 * int'(OD_RST_HALF));
    issue(2'h0, 8'h00);
    wait (pulses == 2);
    mute = 1'b0;
    @(posedge oe);
    chk_bit(pres, 1'b0);
    done();
    chk_bit(pres, 1'b1);
    chk_bit(odv, 1'b1);
    exp_byte(read_scratch_cmd, ODH);
    issue(2'h1, read_scratch_cmd);
    done();
    chk_len(exp_q.size(), 0);
    // two replies queue up before the first pop
    repeat (2)
    begin
      exp_byte(8'hFF, ODH);
      issue(2'h2, 8'h00);
      done();
    end
    pop_chk(reply[7:0]);
    pop_chk(reply[15:8]);
    chk_bit(rv, 1'b0);
    chk_len(exp_q.size(), 0);
    chk_bit(sclk, 1'b0);
    chk_bit(oe, 1'b0);
    summarize();
  end
endmodule
